// >>> tfs_pkg.sv
// Package of offsets, field positions and reset values for the status bank
package tfs_pkg;
  localparam logic [7:0] TFS_OFF_DUTY    = 8'h4E;
  localparam logic [7:0] TFS_OFF_STAT1   = 8'h4F;
  localparam logic [7:0] TFS_OFF_STAT2   = 8'h50;
  localparam logic [7:0] TFS_OFF_STAT3   = 8'h51;
  localparam logic [7:0] TFS_OFF_MASK1   = 8'h52;
  localparam logic [7:0] TFS_OFF_MASK2   = 8'h53;
  localparam logic [7:0] TFS_OFF_MASK3   = 8'h54;
  localparam logic [7:0] TFS_OFF_DLIMIT  = 8'h55;
  localparam logic [7:0] TFS_OFF_SWRST   = 8'h56;
  localparam logic [7:0] TFS_RST_VAL     = 8'h00;
  localparam logic [7:0] TFS_LIMIT_ZERO  = 8'h00;
  localparam logic [7:0] TFS_SWRST_KEY   = 8'h01;
  // Status 1 fields
  localparam int TFS_S1_LOC_HI  = 7;
  localparam int TFS_S1_LOC_LO  = 6;
  localparam int TFS_S1_R1_HI   = 5;
  localparam int TFS_S1_R1_LO   = 4;
  localparam int TFS_S1_R1_DIO  = 3;
  localparam int TFS_S1_R2_HI   = 2;
  localparam int TFS_S1_R2_LO   = 1;
  localparam int TFS_S1_R2_DIO  = 0;
  // Status 2 fields
  localparam int TFS_S2_LOC_OT  = 7;
  localparam int TFS_S2_R1_OT   = 6;
  localparam int TFS_S2_R2_OT   = 5;
  localparam int TFS_S2_DUTY    = 4;
  localparam int TFS_S2_SEEN    = 3;
  localparam int TFS_S2_DRIVE   = 2;
  localparam logic [7:0] TFS_S2_MASK = 8'hFC;
  // Status 3 fields
  localparam int TFS_S3_FAN1    = 7;
  localparam int TFS_S3_FULL    = 6;
  localparam int TFS_S3_FAN2    = 5;
  localparam int TFS_S3_ALERT   = 0;
  localparam logic [7:0] TFS_S3_MASK = 8'hE1;
endpackage : tfs_pkg

// >>> tfs_status_bank.sv
// Status and duty registers of the thermal and fan monitor
//
// Behaviour
// R1: Duty measure register holds overtemp line percentage
// R2: Status1 bit7 set on local high trip
// R3: Status1 bit6 set on local low trip
// R4: Status1 bits5,4 remote one high, low
// R5: Status1 bits2,1 remote two high, low
// R6: Status1 bits3,0 diode faults per conversion
// R7: Status2 bits7,6,5 overtemp limit trips
// R8: Status2 bit4 set when duty exceeds limit
// R9: Read clears bit4; zero limit with line held low re-sets it
// R10: Status2 bit3 set when line driven externally
// R11: Status2 bit2 set when device drives line
// R12: Status3 bits7,5 fan one, two stalled
// R13: Status3 bit6 while fans forced full
// R14: Status3 bit0 while alert output pulled
// R15: All four registers reset to zero
// R16: Reserved bits read zero; writes ignored
`timescale 1ns/100ps
module tfs_status_bank
  import tfs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Event inputs from other clock domains or pins
  input  wire logic [7:0] limit_trip_in,
  input  wire logic [2:0] overtemp_trip_in,
  input  wire logic       overtemp_line_n_in,
  input  wire logic       overtemp_drive_in,
  input  wire logic       duty_over_in,
  input  wire logic [7:0] duty_measure_in,
  input  wire logic       duty_valid_in,
  input  wire logic       fan1_stall_in,
  input  wire logic       fan2_stall_in,
  input  wire logic       full_override_in,
  // Outputs
  output logic      [7:0] overtemp_duty_limit_out,
  output logic            alert_n_out,
  output logic            irq_out
);

  // Two-stage synchronisers for all asynchronous inputs
  localparam int NSYNC = 26;
  // Line pin idles high; reset to idle so no false low follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 26'h0004000;
  logic [NSYNC-1:0] async_w;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign async_w = {limit_trip_in, overtemp_trip_in, overtemp_line_n_in,
                    overtemp_drive_in, duty_over_in, duty_measure_in,
                    duty_valid_in, fan1_stall_in, fan2_stall_in,
                    full_override_in};

  generate
    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
        begin
          sync1_r[i] <= SYNC_IDLE[i];
          sync2_r[i] <= SYNC_IDLE[i];
        end
        else
        begin
          sync1_r[i] <= async_w[i];
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  logic [7:0] s_trip;
  logic [2:0] s_ot;
  logic       s_line_low;
  logic       s_drive;
  logic       s_duty_over;
  logic [7:0] s_duty;
  logic       s_duty_vld;
  logic       s_fan1;
  logic       s_fan2;
  logic       s_full;
  assign {s_trip, s_ot, s_line_low, s_drive, s_duty_over, s_duty,
          s_duty_vld, s_fan1, s_fan2, s_full} =
         {sync2_r[25:18], sync2_r[17:15], ~sync2_r[14], sync2_r[13:0]};

  // Register state
  logic [7:0] duty_r;
  logic [7:0] stat1_r;
  logic [7:0] stat2_r;
  logic [7:0] stat3_r;
  logic [7:0] mask1_r;
  logic [7:0] mask2_r;
  logic [7:0] mask3_r;
  logic [7:0] dlimit_r;
  logic [7:0] stat1_nxt;
  logic [7:0] stat2_nxt;
  logic [7:0] stat3_nxt;
  logic       swrst;
  logic       clr;

  assign swrst = wr_in && addr_in == TFS_OFF_SWRST
                 && wdata_in == TFS_SWRST_KEY;
  assign clr   = reset_in || swrst;

  // Event vectors
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [7:0] ev3;
  logic       duty_zero_rearm;
  assign duty_zero_rearm = dlimit_r == TFS_LIMIT_ZERO && s_line_low;
  assign ev1 = s_trip;  // [R2] [R3] [R4] [R5] [R6]
  always_comb
  begin
    ev2 = 8'h00;
    ev2[TFS_S2_LOC_OT] = s_ot[2];              // [R7]
    ev2[TFS_S2_R1_OT]  = s_ot[1];              // [R7]
    ev2[TFS_S2_R2_OT]  = s_ot[0];              // [R7]
    ev2[TFS_S2_DUTY]   = s_duty_over || duty_zero_rearm; // [R8] [R9]
    ev2[TFS_S2_SEEN]   = s_line_low && !s_drive; // [R10]
    ev2[TFS_S2_DRIVE]  = s_drive;              // [R11]
  end

  // Sticky status, cleared on read; a new event wins over the clear
  always_comb
  begin
    stat1_nxt = stat1_r;
    stat2_nxt = stat2_r;
    if (rd_in && addr_in == TFS_OFF_STAT1)
      stat1_nxt = 8'h00;
    if (rd_in && addr_in == TFS_OFF_STAT2)
      stat2_nxt = 8'h00;                        // [R9]
    stat1_nxt = stat1_nxt | ev1;
    stat2_nxt = (stat2_nxt | ev2) & TFS_S2_MASK; // [R16]
  end

  // Status 3 latches conditions, cleared on read; a new event wins over the clear
  always_comb
  begin
    ev3 = 8'h00;
    ev3[TFS_S3_FAN1] = s_fan1;                  // [R12]
    ev3[TFS_S3_FAN2] = s_fan2;                  // [R12]
    ev3[TFS_S3_FULL] = s_full;                  // [R13]
    ev3[TFS_S3_ALERT] = !alert_n_out;           // [R14]
    stat3_nxt = stat3_r;
    if (rd_in && addr_in == TFS_OFF_STAT3)
      stat3_nxt = 8'h00;
    stat3_nxt = (stat3_nxt | ev3) & TFS_S3_MASK; // [R16]
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr)
    begin
      stat1_r <= TFS_RST_VAL;                   // [R15]
      stat2_r <= TFS_RST_VAL;
      stat3_r <= TFS_RST_VAL;
    end
    else
    begin
      stat1_r <= stat1_nxt;
      stat2_r <= stat2_nxt;
      stat3_r <= stat3_nxt;
    end
  end

  // Duty measure captured from the measurement engine
  always_ff @(posedge mclk_in)
  begin
    if (clr)
      duty_r <= TFS_RST_VAL;                    // [R15]
    else if (s_duty_vld)
      duty_r <= s_duty;                         // [R1]
  end

  // Writable mask and limit registers
  always_ff @(posedge mclk_in)
  begin
    if (clr)
    begin
      mask1_r  <= TFS_RST_VAL;
      mask2_r  <= TFS_RST_VAL;
      mask3_r  <= TFS_RST_VAL;
      dlimit_r <= TFS_RST_VAL;
    end
    else if (wr_in)
    begin
      case (addr_in)
        TFS_OFF_MASK1:  mask1_r  <= wdata_in;
        TFS_OFF_MASK2:  mask2_r  <= wdata_in;
        TFS_OFF_MASK3:  mask3_r  <= wdata_in;
        TFS_OFF_DLIMIT: dlimit_r <= wdata_in;
        default:        ;                       // [R16]
      endcase
    end
  end

  // Alert and interrupt from unmasked sticky bits except status3 bit0
  logic pend;
  assign pend = |(stat1_r & ~mask1_r) || |(stat2_r & ~mask2_r)
                || |(stat3_r & ~mask3_r & ~TFS_S3_MASK)
                || |(stat3_r[7:1] & ~mask3_r[7:1]);
  always_ff @(posedge mclk_in)
  begin
    if (clr)
    begin
      alert_n_out <= 1'b1;
      irq_out     <= 1'b0;
    end
    else
    begin
      alert_n_out <= !pend;
      irq_out     <= pend;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      overtemp_duty_limit_out <= TFS_RST_VAL;
    else
      overtemp_duty_limit_out <= dlimit_r;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        TFS_OFF_DUTY:   rdata_out <= duty_r;
        TFS_OFF_STAT1:  rdata_out <= stat1_r;
        TFS_OFF_STAT2:  rdata_out <= stat2_r;
        TFS_OFF_STAT3:  rdata_out <= stat3_r;
        TFS_OFF_MASK1:  rdata_out <= mask1_r;
        TFS_OFF_MASK2:  rdata_out <= mask2_r;
        TFS_OFF_MASK3:  rdata_out <= mask3_r;
        TFS_OFF_DLIMIT: rdata_out <= dlimit_r;
        default:        rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end

  // Checks on status 1 flags
  a_stat1_sticky: assert property (@(posedge mclk_in) // [R2]
    disable iff (clr)
    ev1 != 8'h00 |=> (stat1_r & $past(ev1)) == $past(ev1))
    else $error("status1 event lost");
  a_loc_high: assert property (@(posedge mclk_in) // [R2]
    disable iff (clr)
    s_trip[TFS_S1_LOC_HI] |=> stat1_r[TFS_S1_LOC_HI])
    else $error("local high flag missing");
  a_loc_low: assert property (@(posedge mclk_in) // [R3]
    disable iff (clr)
    s_trip[TFS_S1_LOC_LO] |=> stat1_r[TFS_S1_LOC_LO])
    else $error("local low flag missing");
  a_rem1_high: assert property (@(posedge mclk_in) // [R4]
    disable iff (clr)
    s_trip[TFS_S1_R1_HI] |=> stat1_r[TFS_S1_R1_HI])
    else $error("remote one high flag missing");
  a_rem2_high: assert property (@(posedge mclk_in) // [R5]
    disable iff (clr)
    s_trip[TFS_S1_R2_HI] |=> stat1_r[TFS_S1_R2_HI])
    else $error("remote two high flag missing");
  a_rem1_diode: assert property (@(posedge mclk_in) // [R6]
    disable iff (clr)
    s_trip[TFS_S1_R1_DIO] |=> stat1_r[TFS_S1_R1_DIO])
    else $error("remote one diode flag missing");
  a_read_clears: assert property (@(posedge mclk_in) // [R4]
    disable iff (clr)
    rd_in && addr_in == TFS_OFF_STAT1 && ev1 == 8'h00 |=> stat1_r == 8'h00)
    else $error("status1 not cleared on read");

  // Checks on status 2 flags
  a_stat2_resv: assert property (@(posedge mclk_in) // [R16]
    disable iff (reset_in)
    stat2_r[1:0] == 2'b00)
    else $error("status2 reserved bits set");
  a_ot_local: assert property (@(posedge mclk_in) // [R7]
    disable iff (clr)
    s_ot[2] |=> stat2_r[TFS_S2_LOC_OT])
    else $error("local overtemp flag missing");
  a_ot_rem1: assert property (@(posedge mclk_in) // [R7]
    disable iff (clr)
    s_ot[1] |=> stat2_r[TFS_S2_R1_OT])
    else $error("remote one overtemp flag missing");
  a_ot_rem2: assert property (@(posedge mclk_in) // [R7]
    disable iff (clr)
    s_ot[0] |=> stat2_r[TFS_S2_R2_OT])
    else $error("remote two overtemp flag missing");
  a_duty_over: assert property (@(posedge mclk_in) // [R8]
    disable iff (clr)
    s_duty_over |=> stat2_r[TFS_S2_DUTY])
    else $error("duty over flag missing");
  a_duty_rearm: assert property (@(posedge mclk_in) // [R9]
    disable iff (clr)
    duty_zero_rearm |=> stat2_r[TFS_S2_DUTY])
    else $error("duty flag not re-set");
  a_stat2_clear: assert property (@(posedge mclk_in) // [R9]
    disable iff (clr)
    rd_in && addr_in == TFS_OFF_STAT2 && ev2 == 8'h00 |=> stat2_r == 8'h00)
    else $error("status2 not cleared on read");
  a_input_seen: assert property (@(posedge mclk_in) // [R10]
    disable iff (clr)
    s_line_low && !s_drive |=> stat2_r[TFS_S2_SEEN])
    else $error("input seen flag missing");
  a_drive_flag: assert property (@(posedge mclk_in) // [R11]
    disable iff (clr)
    s_drive |=> stat2_r[TFS_S2_DRIVE])
    else $error("drive flag missing");

  // Checks on status 3 flags
  a_stat3_resv: assert property (@(posedge mclk_in) // [R16]
    disable iff (reset_in)
    stat3_r[4:1] == 4'h0)
    else $error("status3 reserved bits set");
  a_fan_stall: assert property (@(posedge mclk_in) // [R12]
    disable iff (clr)
    s_fan1 |=> stat3_r[TFS_S3_FAN1])
    else $error("fan stall flag missing");
  a_fan2_stall: assert property (@(posedge mclk_in) // [R12]
    disable iff (clr)
    s_fan2 |=> stat3_r[TFS_S3_FAN2])
    else $error("fan two stall flag missing");
  a_full_speed: assert property (@(posedge mclk_in) // [R13]
    disable iff (clr)
    s_full |=> stat3_r[TFS_S3_FULL])
    else $error("full speed flag missing");
  a_alert_flag: assert property (@(posedge mclk_in) // [R14]
    disable iff (clr)
    !alert_n_out |=> stat3_r[TFS_S3_ALERT])
    else $error("alert flag missing");
  a_alert_level: assert property (@(posedge mclk_in) // [R14]
    disable iff (clr)
    |(stat1_r & ~mask1_r) |=> !alert_n_out)
    else $error("alert not pulled for pending status");
  a_stat3_clear: assert property (@(posedge mclk_in) // [R16]
    disable iff (clr)
    rd_in && addr_in == TFS_OFF_STAT3 && ev3 == 8'h00 |=> stat3_r == 8'h00)
    else $error("status3 not cleared on read");

  // Checks on duty, reset and read port
  a_duty_load: assert property (@(posedge mclk_in) // [R1]
    disable iff (clr)
    s_duty_vld |=> duty_r == $past(s_duty))
    else $error("duty not loaded");
  a_ro_write: assert property (@(posedge mclk_in) // [R16]
    disable iff (clr)
    wr_in && addr_in == TFS_OFF_DUTY && !s_duty_vld
    |=> duty_r == $past(duty_r))
    else $error("read-only duty register written");
  a_reset_zero: assert property (@(posedge mclk_in) // [R15]
    !clr && $past(clr) |-> stat1_r == 8'h00 && stat2_r == 8'h00
    && stat3_r == 8'h00 && duty_r == 8'h00)
    else $error("registers not zero after reset");
  a_swrst_clear: assert property (@(posedge mclk_in) // [R15]
    swrst |=> duty_r == 8'h00 && stat1_r == 8'h00 && mask1_r == 8'h00
    && dlimit_r == 8'h00)
    else $error("soft reset left state");
  a_rdata_idle: assert property (@(posedge mclk_in) // [R16]
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_limit_copy: assert property (@(posedge mclk_in) // [R9]
    !reset_in |=> overtemp_duty_limit_out == $past(dlimit_r))
    else $error("duty limit output stale");

  // Main scenarios
  c_alert: cover property (@(posedge mclk_in) !alert_n_out);
  c_rearm: cover property (@(posedge mclk_in)
    rd_in && addr_in == TFS_OFF_STAT2 && duty_zero_rearm);
  c_swrst: cover property (@(posedge mclk_in) swrst);
  c_duty_over: cover property (@(posedge mclk_in)
    s_duty_over && !duty_zero_rearm);
  c_full_speed: cover property (@(posedge mclk_in) s_full);

endmodule : tfs_status_bank

// >>> tfs_status_bank_tb.sv
// Self-checking testbench of the thermal and fan status register bank
`timescale 1ns/100ps
module tfs_status_bank_tb
  import tfs_pkg::*;
;
  logic       mclk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] trip = 8'h00;
  logic [2:0] ot_trip = 3'h0;
  logic       line_n = 1'b1;
  logic       drive = 1'b0;
  logic       dover = 1'b0;
  logic [7:0] dmeas = 8'h00;
  logic       dvalid = 1'b0;
  logic       fan1 = 1'b0;
  logic       fan2 = 1'b0;
  logic       full = 1'b0;
  logic [7:0] dlimit;
  logic       alert_n;
  logic       irq;
  int         fail_count = 0;
  int         samples_checked = 0;

  always #5 mclk_in = ~mclk_in;

  tfs_status_bank tfs_status_bank_inst (
    .mclk_in                 (mclk_in),
    .reset_in                (reset_in),
    .addr_in                 (addr),
    .wdata_in                (wdata),
    .wr_in                   (wr),
    .rd_in                   (rd),
    .rdata_out               (rdata),
    .limit_trip_in           (trip),
    .overtemp_trip_in        (ot_trip),
    .overtemp_line_n_in      (line_n),
    .overtemp_drive_in       (drive),
    .duty_over_in            (dover),
    .duty_measure_in         (dmeas),
    .duty_valid_in           (dvalid),
    .fan1_stall_in           (fan1),
    .fan2_stall_in           (fan2),
    .full_override_in        (full),
    .overtemp_duty_limit_out (dlimit),
    .alert_n_out             (alert_n),
    .irq_out                 (irq)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task automatic final_report();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, exp, msk, input string m);
    samples_checked++;
    if ((got & msk) !== (exp & msk))
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, exp, msk);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, msk, "read");
  endtask : rd_chk

  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 20 && irq !== v; i++)
    begin
      tick(1);
      #1;
    end
    chk({7'h00, irq}, {7'h00, v}, 8'h01, "irq level");
    if (irq !== v)
      final_report();
  endtask : wait_irq

  initial
  begin
    int i;
    tick(12);
    reset_in <= 1'b0;
    for (i = 0; i < 4; i++)
      rd_chk(TFS_OFF_DUTY + i[7:0], TFS_RST_VAL, 8'hFF);
    chk({6'h00, irq, alert_n}, 8'h01, 8'h03, "idle outputs");
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      trip <= 8'h01 << i[2:0];
      tick(4);
      trip <= 8'h00;
      tick(4);
      rd_chk(TFS_OFF_STAT1, 8'h01 << i[2:0], 8'hFF);
      rd_chk(TFS_OFF_STAT1, 8'h00, 8'hFF);
    end
    $display("test limit trips done");
    for (i = 0; i < 3; i++)
    begin
      ot_trip <= 3'h1 << i[1:0];
      tick(4);
      ot_trip <= 3'h0;
      tick(4);
      rd_chk(TFS_OFF_STAT2, 8'h20 << i[1:0], 8'hFF);
    end
    wr_reg(TFS_OFF_DLIMIT, 8'h40);
    tick(2);
    chk(dlimit, 8'h40, 8'hFF, "duty limit");
    dover <= 1'b1;
    tick(4);
    dover <= 1'b0;
    tick(4);
    rd_chk(TFS_OFF_STAT2, 8'h10, 8'hFF);
    rd_chk(TFS_OFF_STAT2, 8'h00, 8'hFF);
    line_n <= 1'b0;
    tick(4);
    line_n <= 1'b1;
    tick(4);
    rd_chk(TFS_OFF_STAT2, 8'h08, 8'hFF);
    drive <= 1'b1;
    line_n <= 1'b0;
    tick(4);
    drive <= 1'b0;
    line_n <= 1'b1;
    tick(4);
    rd_chk(TFS_OFF_STAT2, 8'h04, 8'hFF);
    // Zero limit with the line held low sets the flag again
    wr_reg(TFS_OFF_DLIMIT, TFS_LIMIT_ZERO);
    line_n <= 1'b0;
    tick(4);
    rd_chk(TFS_OFF_STAT2, 8'h08, 8'h08);
    rd_chk(TFS_OFF_STAT2, 8'h10, 8'h10);
    line_n <= 1'b1;
    tick(4);
    rd_chk(TFS_OFF_STAT2, 8'h00, 8'h03);
    $display("test overtemp line done");
    for (i = 0; i < 3; i++)
    begin
      {fan1, full, fan2} <= 3'h4 >> i[1:0];
      tick(4);
      {fan1, full, fan2} <= 3'h0;
      tick(4);
      rd_chk(TFS_OFF_STAT3, 8'h80 >> i[1:0], 8'hFE);
    end
    $display("test fan status done");
    rd_chk(TFS_OFF_STAT2, 8'h00, 8'hFF);
    wait_irq(1'b0);
    trip <= 8'h80;
    tick(4);
    trip <= 8'h00;
    wait_irq(1'b1);
    chk({7'h00, alert_n}, 8'h00, 8'h01, "alert low");
    tick(2);
    rd_chk(TFS_OFF_STAT3, 8'h01, 8'h01);
    rd_chk(TFS_OFF_STAT1, 8'h80, 8'hFF);
    wait_irq(1'b0);
    wr_reg(TFS_OFF_MASK1, 8'hFF);
    trip <= 8'h01;
    tick(4);
    trip <= 8'h00;
    tick(4);
    chk({7'h00, irq}, 8'h00, 8'hFF, "masked irq");
    rd_chk(TFS_OFF_STAT1, 8'h01, 8'hFF);
    wr_reg(TFS_OFF_MASK1, 8'h00);
    $display("test interrupt done");
    dmeas <= 8'h5A;
    dvalid <= 1'b1;
    tick(4);
    dvalid <= 1'b0;
    tick(4);
    rd_chk(TFS_OFF_DUTY, 8'h5A, 8'hFF);
    wr_reg(TFS_OFF_DUTY, 8'hFF);
    wr_reg(TFS_OFF_STAT1, 8'hFF);
    rd_chk(TFS_OFF_DUTY, 8'h5A, 8'hFF);
    rd_chk(TFS_OFF_STAT1, 8'h00, 8'hFF);
    rd_chk(8'hA0, 8'h00, 8'hFF);
    wr_reg(TFS_OFF_SWRST, TFS_SWRST_KEY);
    tick(2);
    rd_chk(TFS_OFF_DUTY, TFS_RST_VAL, 8'hFF);
    $display("test duty and soft reset done");
    final_report();
  end
endmodule : tfs_status_bank_tb
